// ### ser_regs.svh
// Purpose: constants for the serial exception responder
// Assumes: 50 MHz system clock
// Notes:   timing counts derive from times in their own units
`ifndef SER_REGS_SVH
`define SER_REGS_SVH

// ---------------------------------------------------------------
// exception codes and the timeout display code
// ---------------------------------------------------------------
`define SER_EXC_FUNC      8'h01
`define SER_EXC_ADDR      8'h02
`define SER_EXC_VALUE     8'h03
`define SER_EXC_FAIL      8'h04
`define SER_DISP_TIMEOUT  8'h10

// ---------------------------------------------------------------
// frame layout
// ---------------------------------------------------------------
`define SER_FUNC_ERR_BIT  8'h80
`define SER_CRC_INIT      16'hFFFF
`define SER_CRC_POLY      16'hA001
`define SER_ASC_START     8'h3A
`define SER_ASC_CR        8'h0D
`define SER_ASC_LF        8'h0A
`define SER_RTU_LAST      4'h4
`define SER_ASC_LAST      4'hA

// ---------------------------------------------------------------
// forced keypad link format
// ---------------------------------------------------------------
`define SER_RATE_19200    4'h3
`define SER_FMT_RTU_8N2   4'h0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SER_CLK_NS        20
`define SER_STEP_NS       2000000
`define SER_STEP_MS       2
`define SER_TO_UNIT_MS    100
`define SER_STEP_CYC      (`SER_STEP_NS / `SER_CLK_NS)
`define SER_TO_STEPS      (`SER_TO_UNIT_MS / `SER_STEP_MS)

`endif

// ### ser_pkg.sv
// Purpose: types for the serial exception responder
// Assumes: nothing
// Notes:   gray coded states along idle, wait, send
package ser_pkg;

  typedef enum logic [1:0]
  {
    SER_IDLE = 2'b00,
    SER_WAIT = 2'b01,
    SER_SEND = 2'b11
  } ser_state_t;

endpackage

// ### ser_exception_responder.sv
// Purpose: builds exception replies for a serial command link
// Assumes: an upstream parser flags each received frame and its faults
// Notes:   normal replies are made elsewhere; this block only refuses
`timescale 1ns/1ns
`include "ser_regs.svh"

module ser_exception_responder
  import ser_pkg::*;
#(
  parameter int unsigned STEP_CYC = `SER_STEP_CYC
)
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // received frame report
  input  wire logic       rx_frame_valid,
  input  wire logic       rx_frame_err,
  input  wire logic [7:0] rx_func,
  input  wire logic       rx_func_unsupported,
  input  wire logic       rx_addr_missing,
  input  wire logic       rx_value_bad,
  input  wire logic       rx_cannot_perform,
  output logic            rx_busy,
  // bus activity pin
  input  wire logic       bus_activity_pin,
  // settings
  input  wire logic [7:0] station_addr,
  input  wire logic       ascii_mode_setting,
  input  wire logic [3:0] link_rate_setting,
  input  wire logic [3:0] link_format_setting,
  input  wire logic       handheld_keypad_enable,
  input  wire logic [7:0] response_delay_setting,
  input  wire logic [7:0] timeout_period_setting,
  input  wire logic [1:0] timeout_treatment_setting,
  input  wire logic       display_clear,
  // effective link format
  output logic [3:0]      link_rate_eff,
  output logic [3:0]      link_format_eff,
  output logic            ascii_mode_eff,
  // display
  output logic [7:0]      link_error_display,
  output logic            link_error_show,
  output logic            link_timeout_display,
  // reply byte stream
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  input  wire logic       tx_ready
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ `SER_CRC_POLY) : (r >> 1);
    return r;
  endfunction

  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  // ---------------------------------------------------------------
  // reset release and pin sync
  // ---------------------------------------------------------------
  logic       rst_s1_q, rst_s2_q;
  logic [2:0] act_sync_q;
  logic       act_last_q;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  wire rst_ok = rst_s2_q;

  // only the agreed copy counts, so a glitch on the pin is ignored
  wire act_agree = act_sync_q[1] == act_sync_q[2];
  wire act_edge  = act_agree && (act_sync_q[2] != act_last_q);

  always_ff @(posedge clk_sys or negedge rst_ok)
  begin
    if (!rst_ok)
    begin
      act_sync_q <= 3'h0;
      act_last_q <= 1'b0;
    end
    else
    begin
      act_sync_q <= {act_sync_q[1:0], bus_activity_pin};
      if (act_agree)
        act_last_q <= act_sync_q[2];
    end
  end

  // ---------------------------------------------------------------
  // effective link format
  // ---------------------------------------------------------------
  // keypad override
  assign link_rate_eff   = handheld_keypad_enable ? `SER_RATE_19200 : link_rate_setting;
  assign link_format_eff = handheld_keypad_enable ? `SER_FMT_RTU_8N2 : link_format_setting;
  assign ascii_mode_eff  = handheld_keypad_enable ? 1'b0 : ascii_mode_setting;

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  ser_state_t state_q;
  wire any_cause = rx_func_unsupported | rx_addr_missing | rx_value_bad | rx_cannot_perform;
  wire take      = (state_q == SER_IDLE) && rx_frame_valid && !rx_frame_err && any_cause;
  wire [7:0] code_sel = rx_func_unsupported ? `SER_EXC_FUNC :   // bad function
                        rx_addr_missing     ? `SER_EXC_ADDR :   // bad address
                        rx_value_bad        ? `SER_EXC_VALUE :  // bad value
                                              `SER_EXC_FAIL;    // cannot perform
  assign rx_busy = state_q != SER_IDLE;

  // ---------------------------------------------------------------
  // step divider, restarted per reply so the delay is exact
  // ---------------------------------------------------------------
  logic [16:0] div_q;
  wire step = div_q == 17'(STEP_CYC - 1);

  always_ff @(posedge clk_sys or negedge rst_ok)
  begin
    if (!rst_ok)
      div_q <= 17'h0;
    else if (take || step)
      div_q <= 17'h0;
    else
      div_q <= div_q + 17'h1;
  end

  // ---------------------------------------------------------------
  // bus timeout
  // ---------------------------------------------------------------
  logic [13:0] idle_q;
  logic        to_flag_q;
  wire to_enabled = (timeout_period_setting != 8'h00) && (timeout_treatment_setting <= 2'd2);
  wire traffic    = act_edge || rx_frame_valid;
  wire [13:0] to_limit = 14'(timeout_period_setting * `SER_TO_STEPS);
  wire to_hit     = to_enabled && !traffic && step && (idle_q == to_limit - 14'h1);

  always_ff @(posedge clk_sys or negedge rst_ok)
  begin
    if (!rst_ok)
      idle_q <= 14'h0;
    else if (traffic || !to_enabled)
      idle_q <= 14'h0;
    else if (step && idle_q != to_limit)
      idle_q <= idle_q + 14'h1;
  end

  always_ff @(posedge clk_sys or negedge rst_ok)
  begin
    if (!rst_ok)
      to_flag_q <= 1'b0;
    else if (to_hit)
      to_flag_q <= 1'b1;
    else if (display_clear)
      to_flag_q <= 1'b0;
  end
  assign link_timeout_display = to_flag_q;

  // ---------------------------------------------------------------
  // display; a new event wins over a clear in the same cycle
  // ---------------------------------------------------------------
  logic [7:0] disp_q;
  logic       show_q;

  always_ff @(posedge clk_sys or negedge rst_ok)
  begin
    if (!rst_ok)
    begin
      disp_q <= 8'h00;
      show_q <= 1'b0;
    end
    else if (take)
    begin
      disp_q <= code_sel;
      show_q <= 1'b1;
    end
    else if (to_hit)
    begin
      disp_q <= `SER_DISP_TIMEOUT;
      show_q <= 1'b1;
    end
    else if (display_clear)
      show_q <= 1'b0;
  end
  assign link_error_display = disp_q;
  assign link_error_show    = show_q;

  // ---------------------------------------------------------------
  // reply sequencer
  // ---------------------------------------------------------------
  logic [7:0]  addr_q, func_q, code_q, wait_q;
  logic        asc_q;
  logic [3:0]  idx_q;
  logic [15:0] crc_q;
  logic        buf_in_ready;

  wire [7:0] lrc     = 8'h00 - (addr_q + func_q + code_q);
  wire       last    = idx_q == (asc_q ? `SER_ASC_LAST : `SER_RTU_LAST);
  wire       push    = (state_q == SER_SEND) && buf_in_ready;
  wire       wait_dn = wait_q == 8'h00;

  wire [7:0] rtu_byte = (idx_q == 4'h0) ? addr_q :
                        (idx_q == 4'h1) ? func_q :
                        (idx_q == 4'h2) ? code_q :
                        (idx_q == 4'h3) ? crc_q[7:0] : crc_q[15:8];
  wire [7:0] asc_byte = (idx_q == 4'h0) ? `SER_ASC_START :
                        (idx_q == 4'h1) ? hex_chr(addr_q[7:4]) :
                        (idx_q == 4'h2) ? hex_chr(addr_q[3:0]) :
                        (idx_q == 4'h3) ? hex_chr(func_q[7:4]) :
                        (idx_q == 4'h4) ? hex_chr(func_q[3:0]) :
                        (idx_q == 4'h5) ? hex_chr(code_q[7:4]) :
                        (idx_q == 4'h6) ? hex_chr(code_q[3:0]) :
                        (idx_q == 4'h7) ? hex_chr(lrc[7:4]) :
                        (idx_q == 4'h8) ? hex_chr(lrc[3:0]) :
                        (idx_q == 4'h9) ? `SER_ASC_CR : `SER_ASC_LF;
  wire [7:0] cur_byte = asc_q ? asc_byte : rtu_byte;

  always_ff @(posedge clk_sys or negedge rst_ok)
  begin
    if (!rst_ok)
    begin
      state_q <= SER_IDLE;
      addr_q  <= 8'h00;
      func_q  <= 8'h00;
      code_q  <= 8'h00;
      wait_q  <= 8'h00;
      asc_q   <= 1'b0;
      idx_q   <= 4'h0;
      crc_q   <= `SER_CRC_INIT;
    end
    else
    begin
      case (state_q)
        SER_IDLE:
        begin
          if (take)
          begin
            addr_q  <= station_addr;
            func_q  <= rx_func | `SER_FUNC_ERR_BIT;
            code_q  <= code_sel;
            asc_q   <= ascii_mode_eff;
            wait_q  <= response_delay_setting;
            idx_q   <= 4'h0;
            crc_q   <= `SER_CRC_INIT;
            state_q <= SER_WAIT;
          end
        end
        SER_WAIT:
        begin
          if (wait_dn)
            state_q <= SER_SEND;
          else if (step)
            wait_q <= wait_q - 8'h1;
        end
        SER_SEND:
        begin
          if (push)
          begin
            if (idx_q < 4'h3)
              crc_q <= crc_byte(crc_q, cur_byte);
            idx_q <= idx_q + 4'h1;
            if (last)
              state_q <= SER_IDLE;
          end
        end
        default:
          state_q <= SER_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // two-entry output buffer, a stalled receiver holds the sequencer
  // ---------------------------------------------------------------
  logic [7:0] buf_q [2];
  logic       rd_q, wr_q;
  logic [1:0] cnt_q;

  assign buf_in_ready = cnt_q != 2'd2;
  assign tx_valid     = cnt_q != 2'd0;
  assign tx_data      = buf_q[rd_q];
  wire pop = tx_valid && tx_ready;

  always_ff @(posedge clk_sys or negedge rst_ok)
  begin
    if (!rst_ok)
    begin
      buf_q[0] <= 8'h00;
      buf_q[1] <= 8'h00;
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
      cnt_q    <= 2'd0;
    end
    else
    begin
      if (push)
      begin
        buf_q[wr_q] <= cur_byte;
        wr_q        <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule // ser_exception_responder

// ### ser_exception_responder_assertions.sv
// Purpose: port checks for the exception responder
// Assumes: one clock, rst_n low resets
// Notes:   sees the top module ports only
`timescale 1ns/1ns
module ser_exception_responder_assertions
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // frame report
  input wire logic       rx_frame_valid,
  input wire logic       rx_frame_err,
  input wire logic       rx_func_unsupported,
  input wire logic       rx_addr_missing,
  input wire logic       rx_value_bad,
  input wire logic       rx_cannot_perform,
  input wire logic       rx_busy,
  // settings
  input wire logic       ascii_mode_setting,
  input wire logic [3:0] link_rate_setting,
  input wire logic [3:0] link_format_setting,
  input wire logic       handheld_keypad_enable,
  input wire logic [7:0] timeout_period_setting,
  input wire logic [1:0] timeout_treatment_setting,
  // outputs, and the tx_ready input
  input wire logic [3:0] link_rate_eff,
  input wire logic [3:0] link_format_eff,
  input wire logic       ascii_mode_eff,
  input wire logic [7:0] link_error_display,
  input wire logic       link_error_show,
  input wire logic       link_timeout_display,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_ready
);
  // ----
  // helpers
  // ----
  wire logic       cause = rx_func_unsupported | rx_addr_missing | rx_value_bad | rx_cannot_perform;
  wire logic       take  = rx_frame_valid & !rx_frame_err & !rx_busy & cause;
  // lowest code first, so stacked causes cannot hide code 01
  wire logic [7:0] low   = rx_func_unsupported ? 8'h01 : rx_addr_missing ? 8'h02 :
                           rx_value_bad ? 8'h03 : 8'h04;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_KEY_ON: assert property (handheld_keypad_enable |-> link_rate_eff == 4'h3 &&
    link_format_eff == 4'h0 && !ascii_mode_eff) else $error("keypad format not forced");
  AST_KEY_OFF: assert property (!handheld_keypad_enable |->
    link_rate_eff == link_rate_setting && link_format_eff == link_format_setting &&
    ascii_mode_eff == ascii_mode_setting) else $error("settings not passed through");
  AST_DROP: assert property (rx_frame_valid && rx_frame_err && !rx_busy |=> !rx_busy)
    else $error("bad frame was taken");
  AST_TAKE: assert property (take |=> rx_busy && link_error_show)
    else $error("clean refused frame not taken");
  AST_CODE: assert property (take |=> link_error_display == $past(low))
    else $error("wrong exception code shown");
  AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("stalled byte changed");
  AST_DELAY: assert property (take && !tx_valid |=> !tx_valid [*2])
    else $error("reply left too early");
  AST_QUIET: assert property (!rx_busy && !tx_valid |=> !tx_valid)
    else $error("byte without a reply");
  AST_TO: assert property ($rose(link_timeout_display) |-> link_error_display == 8'h10 &&
    timeout_period_setting != 8'h00 && timeout_treatment_setting <= 2'h2)
    else $error("bad timeout flag");
  cover property (take);
  cover property (tx_valid && !tx_ready);
  cover property ($rose(link_timeout_display));
endmodule // ser_exception_responder_assertions

// ### ser_sink.sv
// Purpose: master side that drains reply bytes
// Assumes: bench reads the queue q
// Notes:   slow takes every other cycle, hold stalls
`timescale 1ns/1ns
module ser_sink
(
  // clock
  input  wire logic       clk_sys,
  // byte stream
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  // pacing
  input  wire logic       hold,
  input  wire logic       slow
);
  logic [7:0] q[$];
  logic       ph_q = 1'b0;
  assign tx_ready = !hold && (!slow || ph_q);
  always @(posedge clk_sys)
  begin
    ph_q <= !ph_q;
    if (tx_valid && tx_ready)
      q.push_back(tx_data);
  end
endmodule // ser_sink

// ### ser_exception_responder_bench.sv
// Purpose: directed frames against the exception responder
// Assumes: STEP_CYC shortened to 10
// Notes:   timeout uses period 1, so 500 idle cycles
`timescale 1ns/1ns
module ser_exception_responder_bench;
  localparam int STEP = 10;
  logic       clk_sys = 1'b0, rst_n = 1'b0, rx_frame_valid = 1'b0, rx_frame_err = 1'b0;
  logic       bus_activity_pin = 1'b0, ascii_mode_setting = 1'b0, display_clear = 1'b0;
  logic       handheld_keypad_enable = 1'b0, hold = 1'b0, slow = 1'b1;
  logic [7:0] rx_func = 8'h00, station_addr = 8'h01, response_delay_setting = 8'h00;
  logic [7:0] timeout_period_setting = 8'h00;
  logic [3:0] causes = 4'h0, link_rate_setting = 4'h5, link_format_setting = 4'h2;
  logic [1:0] timeout_treatment_setting = 2'h0;
  wire logic [3:0] link_rate_eff, link_format_eff;
  wire logic [7:0] link_error_display, tx_data;
  wire logic       rx_busy, ascii_mode_eff, link_error_show, link_timeout_display;
  wire logic       tx_valid, tx_ready;
  int         error_cnt = 0, num_checks = 0, cyc = 0, n;
  logic [7:0] exp[$];
  ser_exception_responder #(.STEP_CYC(STEP)) i_ser_exception_responder (.clk_sys, .rst_n,
    .rx_frame_valid, .rx_frame_err, .rx_func, .rx_func_unsupported(causes[0]),
    .rx_addr_missing(causes[1]), .rx_value_bad(causes[2]), .rx_cannot_perform(causes[3]),
    .rx_busy, .bus_activity_pin, .station_addr, .ascii_mode_setting, .link_rate_setting,
    .link_format_setting, .handheld_keypad_enable, .response_delay_setting,
    .timeout_period_setting, .timeout_treatment_setting, .display_clear, .link_rate_eff,
    .link_format_eff, .ascii_mode_eff, .link_error_display, .link_error_show,
    .link_timeout_display, .tx_valid, .tx_data, .tx_ready);
  ser_sink i_ser_sink (.clk_sys, .tx_valid, .tx_data, .tx_ready, .hold, .slow);
  always #10 clk_sys = !clk_sys;
  // ----
  // tasks
  // ----
  task automatic final_report;
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + v : 8'h37 + v;
  endfunction
  task automatic build(input logic [7:0] f, input logic [7:0] c, input logic asc);
    logic [7:0]  b[3];
    logic [15:0] crc;
    b = '{station_addr, f | 8'h80, c};
    crc = 16'hFFFF;
    exp.delete();
    if (asc)
      exp.push_back(8'h3A);
    foreach (b[i])
    begin
      crc = crc ^ b[i];
      repeat (8) crc = crc[0] ? (crc >> 1) ^ 16'hA001 : crc >> 1;
      exp.push_back(asc ? hx(b[i][7:4]) : b[i]);
      if (asc)
        exp.push_back(hx(b[i][3:0]));
    end
    b[0] = -(b[0] + b[1] + b[2]);
    if (asc)
      exp = {exp, hx(b[0][7:4]), hx(b[0][3:0]), 8'h0D, 8'h0A};
    else
      exp = {exp, crc[7:0], crc[15:8]};
    i_ser_sink.q.delete();
  endtask
  task automatic send(input logic [7:0] f, input logic [3:0] c, input logic e);
    @(negedge clk_sys);
    rx_func = f;
    causes = c;
    rx_frame_err = e;
    rx_frame_valid = 1'b1;
    bus_activity_pin = !bus_activity_pin;
    @(negedge clk_sys);
    rx_frame_valid = 1'b0;
  endtask
  task automatic wait_done(input string nm);
    n = 0;
    while ((rx_busy !== 1'b0 || tx_valid !== 1'b0) && n < 2000)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk({nm, " done"}, 8'h01, {7'h0, n < 2000});
    chk({nm, " len"}, 8'(exp.size()), 8'(i_ser_sink.q.size()));
    foreach (exp[i]) chk(nm, exp[i], i_ser_sink.q[i]);
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("rate", 8'h05, {4'h0, link_rate_eff});
    handheld_keypad_enable = 1'b1;
    ascii_mode_setting = 1'b1;
    #1 chk("fmt", 8'h30, {link_rate_eff, link_format_eff} | ascii_mode_eff);
    for (int k = 0; k < 4; k++)
    begin
      build(8'h06, 8'(k + 1), 1'b0);
      send(8'h06, 4'hF << k, 1'b0);
      wait_done("rtu");
      chk("disp", 8'(k + 1), link_error_display);
      chk("show", 8'h01, {7'h0, link_error_show});
      // the known reply to function 06h with code 02h
      if (k == 1)
      begin
        chk("crc_lo", 8'hC3, i_ser_sink.q[3]);
        chk("crc", 8'hA1, i_ser_sink.q[4]);
      end
    end
    exp.delete();
    i_ser_sink.q.delete();
    send(8'h03, 4'h1, 1'b1);
    repeat (30) @(negedge clk_sys);
    wait_done("drop");
    chk("disp", 8'h04, link_error_display);
    response_delay_setting = 8'h02;
    hold = 1'b1;
    build(8'h10, 8'h01, 1'b0);
    send(8'h10, 4'h1, 1'b0);
    for (n = 1; tx_valid !== 1'b1 && n < 999; n++) @(negedge clk_sys);
    chk("delay", 8'h01, {7'h0, n >= 2 * STEP + 2 && n <= 2 * STEP + 6});
    repeat (20) @(negedge clk_sys);
    chk("stall", 8'h01, {7'h0, rx_busy});
    hold = 1'b0;
    wait_done("slow");
    handheld_keypad_enable = 1'b0;
    response_delay_setting = 8'h00;
    #1 chk("pass", 8'h53, {link_rate_eff, link_format_eff} | ascii_mode_eff);
    build(8'h06, 8'h02, 1'b1);
    send(8'h06, 4'h2, 1'b0);
    wait_done("asc");
    chk("lrc", 8'h37, i_ser_sink.q[7]);
    timeout_period_setting = 8'h01;
    timeout_treatment_setting = 2'h3;
    repeat (700) @(negedge clk_sys);
    chk("to3", 8'h00, {7'h0, link_timeout_display});
    timeout_treatment_setting = 2'h2;
    bus_activity_pin = !bus_activity_pin;
    repeat (400) @(negedge clk_sys);
    chk("to_early", 8'h00, {7'h0, link_timeout_display});
    repeat (200) @(negedge clk_sys);
    chk("to", 8'h10, link_error_display & {8{link_timeout_display}});
    display_clear = 1'b1;
    @(negedge clk_sys);
    display_clear = 1'b0;
    chk("clr", 8'h00, {7'h0, link_timeout_display});
    chk("clr_show", 8'h00, {7'h0, link_error_show});
    final_report;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      final_report;
    end
  end
endmodule // ser_exception_responder_bench
bind ser_exception_responder ser_exception_responder_assertions i_ser_exc_assertions (
  .clk_sys, .rst_n, .rx_frame_valid, .rx_frame_err, .rx_func_unsupported, .rx_addr_missing,
  .rx_value_bad, .rx_cannot_perform, .rx_busy, .ascii_mode_setting, .link_rate_setting,
  .link_format_setting, .handheld_keypad_enable, .timeout_period_setting,
  .timeout_treatment_setting, .link_rate_eff, .link_format_eff, .ascii_mode_eff,
  .link_error_display, .link_error_show, .link_timeout_display, .tx_valid, .tx_data,
  .tx_ready);
